// ==== rtl/float_normalize_round_defines.svh ====
// Constants for the floating normalize and round sequencer
`ifndef FLOAT_NORMALIZE_ROUND_DEFINES_SVH
`define FLOAT_NORMALIZE_ROUND_DEFINES_SVH

// Register byte offsets on the bus
`define FNR_OFF_ACC_LO 8'h00
`define FNR_OFF_ACC_HI 8'h04
`define FNR_OFF_EXT_LO 8'h08
`define FNR_OFF_EXT_HI 8'h0C
`define FNR_OFF_EXP 8'h10
`define FNR_OFF_CTRL 8'h14
`define FNR_OFF_STATUS 8'h18
`define FNR_OFF_IRQ_STAT 8'h1C
`define FNR_OFF_IRQ_MASK 8'h20

// Control register fields
`define FNR_CTRL_ENTRY_LSB 0
`define FNR_CTRL_ENTRY_MSB 1
`define FNR_CTRL_ROUND_BIT 2
`define FNR_CTRL_GO_BIT 3

// Exponent register fields
`define FNR_EXP_COUNT_LSB 0
`define FNR_EXP_HOLD_LSB 16

// Status register fields
`define FNR_STAT_BUSY_BIT 0
`define FNR_STAT_OVF_BIT 1
`define FNR_STAT_RDONE_BIT 2
`define FNR_STAT_DBL_BIT 3
`define FNR_STAT_STATE_LSB 8

// Interrupt status and mask fields
`define FNR_IRQ_DONE_BIT 0
`define FNR_IRQ_OVF_BIT 1
`define FNR_IRQ_ZERO_BIT 2
`define FNR_IRQ_W 3

// Word bit positions; word bit 0 (sign) sits at vector index 35
`define FNR_SIGN_IDX 35
`define FNR_FRAC_MSB_IDX 26
`define FNR_EXT_LOW_MSB_IDX 34
`define FNR_EXPF_HI_IDX 34
`define FNR_EXPF_LO_IDX 27

// Reset values
`define FNR_RST_WORD 36'h0_0000_0000
`define FNR_RST_EXP 9'h000
`define FNR_RST_IRQ 3'h0

// Cycles spent letting the exponent count settle on multiply entry
`define FNR_SETTLE_CYC 4'h2

`endif

// ==== rtl/float_normalize_round_pkg.sv ====
// Types shared by the floating normalize and round sequencer
package float_normalize_round_pkg;

   // Entry point chosen by the calling arithmetic sequence
   typedef enum logic [1:0] {
      ENTRY_FADD,
      ENTRY_FMUL,
      ENTRY_FDIV,
      ENTRY_RSVD
   } entry_e;

   // One controller state for each step of the chain
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DIV_SHIFT,
      ST_SETTLE,
      ST_ENABLE,
      ST_PRESHIFT,
      ST_ZERO_TEST,
      ST_NEGATE_EXP,
      ST_LEFT_SHIFT,
      ST_POST_LOOP,
      ST_ROUND_BRANCH,
      ST_PACK_EXP,
      ST_ROUND_ADD,
      ST_ROUND_REPEAT,
      ST_RETURN
   } norm_step_e;

   // Accumulator and extension register travel as one double word
   typedef struct packed {
      logic [35:0] acc;
      logic [35:0] ext;
   } dbl_word_s;

endpackage : float_normalize_round_pkg

// ==== rtl/float_normalize_round.sv ====
// Floating normalize and round sequencer with a Wishbone register file
//
// How it works
// - Normalized when fraction bit 9 differs from sign, or magnitude half
// - Add entry: enable double shift, bump exponent, right shift once
// - Zero accumulator and clear extension bit 1 after preshift: return
// - A zero result carries a cleared exponent field too
// - Nonzero result: complement exponent count to negative, enter loop
// - Multiply entry: no right shift; double shift, settle, zero test
// - Divide entry: count from holding register, extra right shift
// - Divide zero test uses extension bit 1 only, never bit 2
// - While not normalized, count exponent up and left shift double word
// - After the loop, positive exponent count sets the overflow flag
// - Positive result complements the count back; negative keeps it if not rounding
// - Round only if requested and extension bit 1 is one
// - Rounding makes count positive, adds one, reruns chain from the enable step
// - Round-done flag blocks rounding on the second pass
// - No rounding: pack count into exponent field, return to store
// - Rounding is away from zero by half an LSB threshold
// - Divide leaves remainder sign in bit 0, truncated remainder 11-35
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "float_normalize_round_defines.svh"

module float_normalize_round #(
   parameter int EXP_W = 9,
   parameter int WORD_W = 36
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic irq_out,
   output logic busy_out,
   output logic return_pulse_out
);

   // Widths are fixed by the word format of the datapath
   if (EXP_W != 9 || WORD_W != 36) begin : g_bad_width
      $error("float_normalize_round serves only 9-bit counts, 36-bit words");
   end

   ////////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////////

   float_normalize_round_pkg::norm_step_e state_q;
   float_normalize_round_pkg::entry_e entry_q;
   float_normalize_round_pkg::dbl_word_s word_q;
   logic [8:0] exponent_count_q;
   logic [8:0] exponent_holding_reg_q;
   logic round_request_bit_q;
   logic dbl_shift_enable_flag_q;
   logic round_done_flag_q;
   logic overflow_q;
   logic [3:0] settle_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_event;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   ////////////////////////////////////////////////////////////////////////

   logic bus_req;
   logic bus_wr;
   logic go_cmd;
   logic idle;

   // A request is served once; ack drops in the cycle after it was given
   assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign bus_wr = bus_req & wb_we_in;
   assign idle = (state_q == float_normalize_round_pkg::ST_IDLE);
   assign go_cmd = bus_wr & (wb_adr_in == `FNR_OFF_CTRL) & wb_sel_in[0]
      & wb_dat_in[`FNR_CTRL_GO_BIT] & idle;

   // Merge write data into an old value under the byte lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   ////////////////////////////////////////////////////////////////////////
   // Datapath helpers
   ////////////////////////////////////////////////////////////////////////

   // Double-length arithmetic right shift; extension sign bit stays put
   function automatic float_normalize_round_pkg::dbl_word_s shift_right(
      input float_normalize_round_pkg::dbl_word_s w, input logic dbl);
      float_normalize_round_pkg::dbl_word_s r;
      r.acc = {w.acc[35], w.acc[35:1]};
      r.ext = dbl ? {w.ext[35], w.acc[0], w.ext[34:1]} : w.ext;
      return r;
   endfunction : shift_right

   // Double-length arithmetic left shift; zero enters at the far end
   function automatic float_normalize_round_pkg::dbl_word_s shift_left(
      input float_normalize_round_pkg::dbl_word_s w, input logic dbl);
      float_normalize_round_pkg::dbl_word_s r;
      r.acc = {w.acc[35], w.acc[33:0], dbl ? w.ext[34] : 1'b0};
      r.ext = dbl ? {w.ext[35], w.ext[33:0], 1'b0} : w.ext;
      return r;
   endfunction : shift_left

   logic acc_sign;
   logic frac_msb;
   logic low_msb;
   logic frac_half;
   logic normalized;
   logic result_zero;
   logic round_gate;

   // Magnitude one half: fraction msb set with every lower fraction bit clear
   assign acc_sign = word_q.acc[`FNR_SIGN_IDX];
   assign frac_msb = word_q.acc[`FNR_FRAC_MSB_IDX];
   assign low_msb = word_q.ext[`FNR_EXT_LOW_MSB_IDX];
   assign frac_half = frac_msb & (word_q.acc[25:0] == 26'h0000000);
   assign normalized = (frac_msb != acc_sign) | frac_half;
   // Bit 2 of the extension is ignored: it holds a rounding-only bit
   assign result_zero = ~|word_q.acc & ~low_msb;
   assign round_gate = round_request_bit_q & low_msb
      & ~round_done_flag_q;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and datapath
   ////////////////////////////////////////////////////////////////////////

   // Software loads operands only while idle, so the chain never races it
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_q <= float_normalize_round_pkg::ST_IDLE;
         entry_q <= float_normalize_round_pkg::ENTRY_FADD;
         word_q <= '0;
         exponent_count_q <= `FNR_RST_EXP;
         exponent_holding_reg_q <= `FNR_RST_EXP;
         round_request_bit_q <= 1'b0;
         dbl_shift_enable_flag_q <= 1'b0;
         round_done_flag_q <= 1'b0;
         overflow_q <= 1'b0;
         settle_q <= 4'h0;
      end else if (ce_in) begin
         case (state_q)
            float_normalize_round_pkg::ST_IDLE: begin
               if (bus_wr) begin
                  case (wb_adr_in)
                     `FNR_OFF_ACC_LO: begin
                        word_q.acc[31:0] <= lane_merge(word_q.acc[31:0],
                           wb_dat_in, wb_sel_in);
                     end
                     `FNR_OFF_ACC_HI: begin
                        if (wb_sel_in[0]) begin
                           word_q.acc[35:32] <= wb_dat_in[3:0];
                        end
                     end
                     `FNR_OFF_EXT_LO: begin
                        word_q.ext[31:0] <= lane_merge(word_q.ext[31:0],
                           wb_dat_in, wb_sel_in);
                     end
                     `FNR_OFF_EXT_HI: begin
                        if (wb_sel_in[0]) begin
                           word_q.ext[35:32] <= wb_dat_in[3:0];
                        end
                     end
                     `FNR_OFF_EXP: begin
                        if (wb_sel_in[1:0] == 2'h3) begin
                           exponent_count_q <= wb_dat_in[8:0];
                        end
                        if (wb_sel_in[3:2] == 2'h3) begin
                           exponent_holding_reg_q <= wb_dat_in[24:16];
                        end
                     end
                     default: begin
                     end
                  endcase
               end
               if (go_cmd) begin
                  entry_q <= float_normalize_round_pkg::entry_e'(
                     wb_dat_in[1:0]);
                  round_request_bit_q <= wb_dat_in[`FNR_CTRL_ROUND_BIT];
                  round_done_flag_q <= 1'b0;
                  overflow_q <= 1'b0;
                  case (wb_dat_in[1:0])
                     2'h1: begin
                        dbl_shift_enable_flag_q <= 1'b1;
                        settle_q <= `FNR_SETTLE_CYC;
                        state_q <= float_normalize_round_pkg::ST_SETTLE;
                     end
                     2'h2: begin
                        dbl_shift_enable_flag_q <= 1'b1;
                        exponent_count_q <= exponent_holding_reg_q;
                        state_q <= float_normalize_round_pkg::ST_DIV_SHIFT;
                     end
                     default: begin
                        state_q <= float_normalize_round_pkg::ST_ENABLE;
                     end
                  endcase
               end
            end
            // Divide: extra right shift; the chain supplies the second
            float_normalize_round_pkg::ST_DIV_SHIFT: begin
               word_q <= shift_right(word_q, dbl_shift_enable_flag_q);
               state_q <= float_normalize_round_pkg::ST_ENABLE;
            end
            // Multiply cannot overflow, so it waits and joins at the zero test
            float_normalize_round_pkg::ST_SETTLE: begin
               if (settle_q <= 4'h1) begin
                  state_q <= float_normalize_round_pkg::ST_ZERO_TEST;
               end else begin
                  settle_q <= settle_q - 4'h1;
               end
            end
            float_normalize_round_pkg::ST_ENABLE: begin
               dbl_shift_enable_flag_q <= 1'b1;
               state_q <= float_normalize_round_pkg::ST_PRESHIFT;
            end
            // Halving the fraction and bumping the exponent keeps the value
            float_normalize_round_pkg::ST_PRESHIFT: begin
               exponent_count_q <= exponent_count_q + 9'h001;
               word_q <= shift_right(word_q, dbl_shift_enable_flag_q);
               state_q <= float_normalize_round_pkg::ST_ZERO_TEST;
            end
            float_normalize_round_pkg::ST_ZERO_TEST: begin
               if (result_zero) begin
                  state_q <= float_normalize_round_pkg::ST_RETURN;
               end else begin
                  state_q <= float_normalize_round_pkg::ST_NEGATE_EXP;
               end
            end
            float_normalize_round_pkg::ST_NEGATE_EXP: begin
               exponent_count_q <= ~exponent_count_q;
               state_q <= float_normalize_round_pkg::ST_LEFT_SHIFT;
            end
            // One shift per clock until the fraction is normalized
            float_normalize_round_pkg::ST_LEFT_SHIFT: begin
               if (normalized) begin
                  state_q <= float_normalize_round_pkg::ST_POST_LOOP;
               end else begin
                  exponent_count_q <= exponent_count_q + 9'h001;
                  word_q <= shift_left(word_q, dbl_shift_enable_flag_q);
               end
            end
            // One complement serves both a positive result and a round pass
            float_normalize_round_pkg::ST_POST_LOOP: begin
               if (!exponent_count_q[8]) begin
                  overflow_q <= 1'b1;
               end
               if (!acc_sign || round_gate) begin
                  exponent_count_q <= ~exponent_count_q;
               end
               state_q <= float_normalize_round_pkg::ST_ROUND_BRANCH;
            end
            float_normalize_round_pkg::ST_ROUND_BRANCH: begin
               if (round_gate) begin
                  state_q <= float_normalize_round_pkg::ST_ROUND_ADD;
               end else begin
                  state_q <= float_normalize_round_pkg::ST_PACK_EXP;
               end
            end
            // Adding one both rounds away from zero and fixes negative form
            float_normalize_round_pkg::ST_ROUND_ADD: begin
               word_q.acc <= word_q.acc + 36'h0_0000_0001;
               state_q <= float_normalize_round_pkg::ST_ROUND_REPEAT;
            end
            // The rerun absorbs a round overflow of an all-ones fraction
            float_normalize_round_pkg::ST_ROUND_REPEAT: begin
               round_done_flag_q <= 1'b1;
               state_q <= float_normalize_round_pkg::ST_ENABLE;
            end
            float_normalize_round_pkg::ST_PACK_EXP: begin
               word_q.acc[`FNR_EXPF_HI_IDX:`FNR_EXPF_LO_IDX] <=
                  exponent_count_q[7:0];
               state_q <= float_normalize_round_pkg::ST_RETURN;
            end
            float_normalize_round_pkg::ST_RETURN: begin
               if (result_zero) begin
                  // Zero keeps a cleared exponent field
                  word_q.acc[`FNR_EXPF_HI_IDX:`FNR_EXPF_LO_IDX] <= 8'h00;
               end
               dbl_shift_enable_flag_q <= 1'b0;
               state_q <= float_normalize_round_pkg::ST_IDLE;
            end
            default: begin
               state_q <= float_normalize_round_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events and interrupt
   ////////////////////////////////////////////////////////////////////////

   // Done fires on the return step, zero on the zero test; overflow when the loop ends
   always_comb begin
      irq_event = 3'h0;
      irq_event[`FNR_IRQ_DONE_BIT] =
         (state_q == float_normalize_round_pkg::ST_RETURN);
      irq_event[`FNR_IRQ_ZERO_BIT] =
         (state_q == float_normalize_round_pkg::ST_ZERO_TEST) & result_zero;
      irq_event[`FNR_IRQ_OVF_BIT] =
         (state_q == float_normalize_round_pkg::ST_POST_LOOP)
         & ~exponent_count_q[8];
   end

   // Write one to clear; an event in the same cycle wins over the clear
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         irq_stat_q <= `FNR_RST_IRQ;
         irq_mask_q <= `FNR_RST_IRQ;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         if (bus_wr && wb_sel_in[0] && wb_adr_in == `FNR_OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_in[2:0]) | irq_event;
         end else begin
            irq_stat_q <= irq_stat_q | irq_event;
         end
         if (bus_wr && wb_sel_in[0] && wb_adr_in == `FNR_OFF_IRQ_MASK) begin
            irq_mask_q <= wb_dat_in[2:0];
         end
         irq_out <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer and status outputs
   ////////////////////////////////////////////////////////////////////////

   logic [31:0] rd_data;

   // Unmapped offsets read as zero and are still acknowledged
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_in)
         `FNR_OFF_ACC_LO: rd_data = word_q.acc[31:0];
         `FNR_OFF_ACC_HI: rd_data[3:0] = word_q.acc[35:32];
         `FNR_OFF_EXT_LO: rd_data = word_q.ext[31:0];
         `FNR_OFF_EXT_HI: rd_data[3:0] = word_q.ext[35:32];
         `FNR_OFF_EXP: begin
            rd_data[8:0] = exponent_count_q;
            rd_data[24:16] = exponent_holding_reg_q;
         end
         `FNR_OFF_CTRL: begin
            rd_data[1:0] = entry_q;
            rd_data[`FNR_CTRL_ROUND_BIT] = round_request_bit_q;
         end
         `FNR_OFF_STATUS: begin
            rd_data[`FNR_STAT_BUSY_BIT] = ~idle;
            rd_data[`FNR_STAT_OVF_BIT] = overflow_q;
            rd_data[`FNR_STAT_RDONE_BIT] = round_done_flag_q;
            rd_data[`FNR_STAT_DBL_BIT] = dbl_shift_enable_flag_q;
            rd_data[11:8] = state_q;
         end
         `FNR_OFF_IRQ_STAT: rd_data[2:0] = irq_stat_q;
         `FNR_OFF_IRQ_MASK: rd_data[2:0] = irq_mask_q;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Every access answers one cycle after the request is seen
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else if (ce_in) begin
         wb_ack_out <= bus_req;
         if (bus_req) begin
            wb_dat_out <= rd_data;
         end
      end
   end

   // Busy and the one-cycle return strobe toward the store step
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         busy_out <= 1'b0;
         return_pulse_out <= 1'b0;
      end else if (ce_in) begin
         busy_out <= ~idle | go_cmd;
         return_pulse_out <= (state_q == float_normalize_round_pkg::ST_RETURN);
      end
   end

endmodule : float_normalize_round

// ==== tb/fnr_properties.sv ====
// Port-level checks of the normalize and round sequencer
`timescale 1ns/1ns
module fnr_props (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic busy_out,
   input wire logic return_pulse_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////////
   // Bus answers in the cycle after the request edge, for one cycle
   AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
      && ce_in |=> wb_ack_out) else $error("ack not given");
   AST_ACK_PULSE: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
      else $error("ack held");
   // Unmapped reads give zero; the start bit never reads back
   AST_UNMAPPED: assert property (wb_ack_out && !wb_we_in
      && wb_adr_in > 8'h20 |-> wb_dat_out == 32'h0) else $error("unmapped");
   AST_GO_ZERO: assert property (wb_ack_out && !wb_we_in
      && wb_adr_in == 8'h14 |-> !wb_dat_out[3]) else $error("go reads 1");
   // A run starts only from a start write and ends within a bound
   AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> wb_ack_out
      && wb_we_in && wb_adr_in == 8'h14 && wb_dat_in[3])
      else $error("busy without start");
   AST_RUN_BOUND: assert property ($rose(busy_out)
      |-> ##[3:250] return_pulse_out) else $error("run too long");
   AST_RET_PULSE: assert property (return_pulse_out
      |=> !return_pulse_out) else $error("return held");
   AST_RET_BUSY: assert property (return_pulse_out
      |-> $past(busy_out) ##[0:2] !busy_out) else $error("return idle");
   // Reset silences busy, ack and the return strobe on the next cycle
   AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn_in && ce_in
      |=> !busy_out && !wb_ack_out && !return_pulse_out)
      else $error("reset noisy");
endmodule : fnr_props
bind float_normalize_round fnr_props u_props (.ref_clk_in(ref_clk_in),
   .resetn_in(resetn_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .busy_out(busy_out), .return_pulse_out(return_pulse_out));

// ==== tb/fnr_caller_model.sv ====
// Calling-sequence model: bus master that starts one normalize run
`timescale 1ns/1ns
module fnr_caller_model (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [31:0] rdat_in,
   input wire logic ret_in,
   output logic cyc_out,
   output logic stb_out,
   output logic we_out,
   output logic [7:0] adr_out,
   output logic [3:0] sel_out,
   output logic [31:0] wdat_out
);
   // Idle bus at time zero
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      adr_out = 8'h00;
      sel_out = 4'hF;
      wdat_out = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // One classic cycle, held until ack is sampled; released data is
   // inverted so a stale value can never pass for fresh write data
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      wdat_out <= d;
      @(posedge clk_in);
      while (ack_in !== 1'b1) begin
         @(posedge clk_in);
      end
      q = rdat_in;
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
      wdat_out <= ~d;
      @(posedge clk_in);
   endtask : bus
   // Start a run and wait for the return to the store step
   task automatic launch(input logic [1:0] e, input logic r);
      logic [31:0] q;
      bus(1'b1, 8'h14, {28'h0, 1'b1, r, e}, q);
      while (ret_in !== 1'b1) begin
         @(posedge clk_in);
      end
   endtask : launch
endmodule : fnr_caller_model

// ==== tb/tb.sv ====
// Self-checking bench for the normalize and round sequencer
`timescale 1ns/1ns
module tb;
   logic ref_clk_in, resetn_in, cyc, stb, we, ack, irq, busy, ret;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic [35:0] a, x;
   logic [26:0] f;
   logic [8:0] s, h;
   int fails, checks_done, seed, cyc_n;
   float_normalize_round uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .irq_out(irq), .busy_out(busy),
      .return_pulse_out(ret));
   fnr_caller_model host (.clk_in(ref_clk_in), .ack_in(ack), .rdat_in(rdat),
      .ret_in(ret), .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
      .sel_out(sel), .wdat_out(wdat));
   ////////////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   // Hang guard; a whole run needs under two thousand cycles
   always @(posedge ref_clk_in) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n > 20000) begin
         fails = fails + 1;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Reference chain; one loop pass per round, the second never rounds
   function automatic void norm_model(inout logic [35:0] a,
      inout logic [35:0] x, inout logic [8:0] s, input logic [8:0] h,
      input logic [1:0] e, input logic r, output logic [2:0] ist);
      logic rd;
      logic g;
      rd = 1'b0;
      ist = 3'h1;
      if (e == 2'h2) begin
         s = h;
         {a, x} = {a[35], a[35:1], x[35], a[0], x[34:1]};
      end
      for (int p = 0; p < 2; p++) begin
         if (p == 1 || e != 2'h1) begin
            s = s + 9'h001;
            {a, x} = {a[35], a[35:1], x[35], a[0], x[34:1]};
         end
         if (a == 36'h0 && !x[34]) begin
            ist[2] = 1'b1;
            return;
         end
         s = ~s;
         while (a[35] == a[26] && !(a[26] && a[25:0] == 26'h0)) begin
            s = s + 9'h001;
            {a, x} = {a[35], a[33:0], x[34], x[35], x[33:0], 1'b0};
         end
         if (!s[8]) ist[1] = 1'b1;
         g = r & x[34] & ~rd;
         if (!a[35] || g) s = ~s;
         if (!g) begin
            a[34:27] = s[7:0];
            return;
         end
         a = a + 36'h1;
         rd = 1'b1;
      end
   endfunction : norm_model
   // Load operands, run, then compare accumulator, count, status, interrupt and control
   task automatic run_case(input logic [35:0] a, input logic [35:0] x,
      input logic [8:0] s, input logic [8:0] h, input logic [1:0] e,
      input logic r, input logic [2:0] m);
      logic [31:0] lo, hi, q;
      logic [2:0] ist;
      host.bus(1'b1, 8'h20, {29'h0, m}, q);
      host.bus(1'b1, 8'h00, a[31:0], q);
      host.bus(1'b1, 8'h04, {28'h0, a[35:32]}, q);
      host.bus(1'b1, 8'h08, x[31:0], q);
      host.bus(1'b1, 8'h0C, {28'h0, x[35:32]}, q);
      host.bus(1'b1, 8'h10, {7'h0, h, 7'h0, s}, q);
      host.launch(e, r);
      norm_model(a, x, s, h, e, r, ist);
      host.bus(1'b0, 8'h00, 32'h0, lo);
      host.bus(1'b0, 8'h04, 32'h0, hi);
      check({hi[3:0], lo}, a);
      host.bus(1'b0, 8'h10, 32'h0, q);
      check(q[8:0], s);
      host.bus(1'b0, 8'h18, 32'h0, q);
      check(q[1:0], {ist[1], 1'b0});
      host.bus(1'b0, 8'h1C, 32'h0, q);
      check(q[2:0], ist);
      check(irq, |(m & ist));
      host.bus(1'b0, 8'h14, 32'h0, q);
      check(q[3:0], {1'b0, r, e});
      host.bus(1'b1, 8'h1C, 32'h7, q);
      check(irq, 1'b0);
      $display("case entry=%0h round=%0h done", e, r);
   endtask : run_case
   // Main sequence: fixed corner cases, then random runs of every entry
   initial begin
      seed = 31;
      fails = 0;
      checks_done = 0;
      cyc_n = 0;
      resetn_in = 1'b0;
      repeat (5) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      @(posedge ref_clk_in);
      run_case(36'h0, 36'h0, 9'h005, 9'h0, 2'h0, 1'b1, 3'h7);
      run_case(36'h1, 36'h0, 9'h005, 9'h003, 2'h2, 1'b1, 3'h7);
      run_case(36'h1, 36'h0, 9'h005, 9'h0, 2'h0, 1'b1, 3'h7);
      run_case(36'h0_0400_0000, 36'h0, 9'h0FF, 9'h0, 2'h1, 1'b0, 3'h7);
      for (int i = 0; i < 12; i++) begin
         f = 27'($random(seed)) >> ($random(seed) & 15);
         a = ($random(seed) & 1) ? ~{9'h000, f} : {9'h000, f};
         x = {1'b0, 3'($random(seed)), 32'($random(seed))};
         s = 9'($random(seed) & 255);
         h = 9'($random(seed) & 255);
         run_case(a, x, s, h, 2'(i % 4), 1'($random(seed)),
            (i == 11) ? 3'h0 : 3'h7);
      end
      host.bus(1'b0, 8'h24, 32'h0, q);
      check(q, 32'h0);
      test_done();
   end
endmodule : tb
